// ---- serdes_pkg.sv ----
package serdes_pkg;
  localparam int WORD_W = 10;
  // 10-bit comma characters, first serial bit in bit 9
  localparam logic [9:0] COMMA_RD_NEG = 10'h0FA;
  localparam logic [9:0] COMMA_RD_POS = 10'h305;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] HALF_WORD = 4'h5;
  // recovered word clock: high from this phase, five bit times early, four late
  localparam logic [3:0] RX_WORD_CLOCK_RISE_EARLY = 4'h4;
  localparam logic [3:0] RX_WORD_CLOCK_RISE_LATE = 4'h6;
  // bits without a transition before the input counts as absent
  localparam logic [6:0] SILENT_BITS = 7'h40;
  // reference clock is one fortieth of the baud rate
  localparam int REF_BAUD_RATIO = 40;
  localparam int REF_ACQ_EDGES = 2;
  localparam logic [1:0] REF_ACQ_CNT = 2'(REF_ACQ_EDGES);
  // timing
  localparam int CLK_MHZ = 200;
  localparam int SYNC_COLD_MS = 1;
  localparam int SYNC_WARM_US = 200;
  localparam int SYNC_COLD_CYC = SYNC_COLD_MS * 1000 * CLK_MHZ;
  localparam int SYNC_WARM_CYC = SYNC_WARM_US * CLK_MHZ;
  localparam int TIMER_W = 18;
  // reset values
  localparam logic [9:0] WORD_RESET = 10'h000;
  localparam logic [3:0] CNT_RESET = 4'h0;
endpackage

// ---- comma_detect.sv ----
`timescale 1ns/100ps
module comma_detect #(
  parameter int W = 10,
  parameter logic [W-1:0] PAT_A = '0,
  parameter logic [W-1:0] PAT_B = '0
) (
  // candidate window
  input wire logic [W-1:0] win,
  // match
  output logic hit
);
  always_comb begin
    hit = (win == PAT_A) || (win == PAT_B);
  end
endmodule

// ---- gigabit_serdes_comma_align.sv ----
`timescale 1ns/100ps
module gigabit_serdes_comma_align #(
  parameter int SYNC_COLD_CYC = serdes_pkg::SYNC_COLD_CYC,
  parameter int SYNC_WARM_CYC = serdes_pkg::SYNC_WARM_CYC
) (
  // system
  input wire logic clk,
  input wire logic nrst,
  input wire logic reference_clock,
  // transmit parallel side
  input wire logic [9:0] tx_word,
  input wire logic tx_word_strobe,
  output logic word_clock_out,
  // serial outputs
  output logic line_out_pos,
  output logic line_out_neg,
  output logic loop_out_pos,
  output logic loop_out_neg,
  // serial inputs
  input wire logic line_in_pos,
  input wire logic line_in_neg,
  input wire logic loop_in_pos,
  input wire logic loop_in_neg,
  // configuration
  input wire logic loop_select,
  input wire logic baud_select,
  input wire logic align_enable,
  input wire logic rx_edge_select,
  // receive parallel side
  output logic [9:0] rx_word,
  output logic rx_word_clock,
  output logic align_sync,
  output logic cdr_locked,
  output logic cdr_tracking
);
  typedef enum logic [1:0] {ACQUIRE, RECOVER, LOCKED} cdr_state_t;

  // reference clock domain: heartbeat toggle
  logic ref_rst_s1, ref_rst_s2;
  logic ref_toggle, next_ref_toggle;

  always_ff @(posedge reference_clock or negedge nrst) begin
    if (!nrst) begin
      ref_rst_s1 <= 1'b0;
      ref_rst_s2 <= 1'b0;
    end else begin
      ref_rst_s1 <= 1'b1;
      ref_rst_s2 <= ref_rst_s1;
    end
  end

  always_comb begin
    next_ref_toggle = ref_rst_s2 ? ~ref_toggle : ref_toggle;
  end

  always_ff @(posedge reference_clock or negedge nrst) begin
    if (!nrst) ref_toggle <= 1'b0;
    else ref_toggle <= next_ref_toggle;
  end

  // input synchronisers
  localparam int PIN_W = 20;
  logic [PIN_W-1:0] pin_raw, pin_s1, pin_s2;
  logic ref_d;
  assign pin_raw = {ref_toggle, rx_edge_select, align_enable, baud_select,
                    loop_select, loop_in_neg, loop_in_pos, line_in_neg,
                    line_in_pos, tx_word_strobe, tx_word};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      ref_d <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      ref_d <= pin_s2[19];
    end
  end

  logic [9:0] tx_word_s;
  logic strobe_s, loop_s, baud_low, align_en_s, edge_s, ref_event;
  logic rx_bit;
  assign tx_word_s = pin_s2[9:0];
  assign strobe_s = pin_s2[10];
  assign loop_s = pin_s2[15];
  assign baud_low = pin_s2[16];
  assign align_en_s = pin_s2[17];
  assign edge_s = pin_s2[18];
  assign ref_event = pin_s2[19] ^ ref_d;
  // receive mux feeding recovery
  assign rx_bit = loop_s ? (pin_s2[13] & ~pin_s2[14])
                         : (pin_s2[11] & ~pin_s2[12]);

  // bit timing: one enable per bit at either rate
  logic bit_phase, next_bit_phase, bit_en;
  always_comb begin
    next_bit_phase = baud_low ? ~bit_phase : 1'b0;
    bit_en = baud_low ? bit_phase : 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bit_phase <= 1'b0;
    else bit_phase <= next_bit_phase;
  end

  // transmit path
  logic [9:0] tx_hold, next_tx_hold, tx_shift, next_tx_shift;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic strobe_d, strobe_rise;
  logic next_word_clock_out, next_line_out_pos, next_line_out_neg;
  logic next_loop_out_pos, next_loop_out_neg;

  always_comb begin
    strobe_rise = strobe_s & ~strobe_d;
    next_tx_hold = strobe_rise ? tx_word_s : tx_hold;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    if (bit_en) begin
      if (tx_cnt == serdes_pkg::LAST_BIT) begin
        next_tx_cnt = serdes_pkg::CNT_RESET;
        next_tx_shift = tx_hold;
      end else begin
        next_tx_cnt = 4'(tx_cnt + 4'h1);
        next_tx_shift = {tx_shift[8:0], 1'b0};
      end
    end
    next_word_clock_out = next_tx_cnt < serdes_pkg::HALF_WORD;
    next_line_out_pos = ~loop_s & next_tx_shift[9];
    next_line_out_neg = loop_s | ~next_tx_shift[9];
    next_loop_out_pos = loop_s & next_tx_shift[9];
    next_loop_out_neg = ~loop_s | ~next_tx_shift[9];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold <= serdes_pkg::WORD_RESET;
      tx_shift <= serdes_pkg::WORD_RESET;
      tx_cnt <= serdes_pkg::CNT_RESET;
      strobe_d <= 1'b0;
      word_clock_out <= 1'b1;
      line_out_pos <= 1'b0;
      line_out_neg <= 1'b1;
      loop_out_pos <= 1'b0;
      loop_out_neg <= 1'b1;
    end else begin
      tx_hold <= next_tx_hold;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      strobe_d <= strobe_s;
      word_clock_out <= next_word_clock_out;
      line_out_pos <= next_line_out_pos;
      line_out_neg <= next_line_out_neg;
      loop_out_pos <= next_loop_out_pos;
      loop_out_neg <= next_loop_out_neg;
    end
  end

  // clock and data recovery state
  cdr_state_t cdr_state, next_cdr_state;
  logic [6:0] quiet_cnt, next_quiet_cnt;
  logic [serdes_pkg::TIMER_W-1:0] lock_timer, next_lock_timer;
  logic [serdes_pkg::TIMER_W-1:0] lock_limit;
  logic [1:0] ref_cnt, next_ref_cnt;
  logic warm, next_warm, prev_bit, next_prev_bit, present;
  logic next_cdr_locked, next_cdr_tracking;

  always_comb begin
    present = quiet_cnt < serdes_pkg::SILENT_BITS;
    lock_limit = warm ? serdes_pkg::TIMER_W'(SYNC_WARM_CYC - 1)
                      : serdes_pkg::TIMER_W'(SYNC_COLD_CYC - 1);
    next_prev_bit = bit_en ? rx_bit : prev_bit;
    next_quiet_cnt = quiet_cnt;
    if (bit_en) begin
      if (rx_bit != prev_bit) next_quiet_cnt = 7'h00;
      else if (present) next_quiet_cnt = 7'(quiet_cnt + 7'h01);
    end
    next_ref_cnt = ref_cnt;
    if (ref_event && ref_cnt != serdes_pkg::REF_ACQ_CNT) begin
      next_ref_cnt = 2'(ref_cnt + 2'h1);
    end
    next_cdr_state = cdr_state;
    next_lock_timer = lock_timer;
    next_warm = warm;
    case (cdr_state)
      ACQUIRE: begin
        // frequency held on the reference until data shows up
        next_lock_timer = '0;
        if (ref_cnt == serdes_pkg::REF_ACQ_CNT && present) begin
          next_cdr_state = RECOVER;
        end
      end
      RECOVER: begin
        if (!present) begin
          next_cdr_state = ACQUIRE;
        end else if (lock_timer == lock_limit) begin
          next_cdr_state = LOCKED;
          next_warm = 1'b1;
        end else begin
          next_lock_timer = serdes_pkg::TIMER_W'(lock_timer + 1'b1);
        end
      end
      LOCKED: begin
        if (!present) next_cdr_state = ACQUIRE;
      end
      default: next_cdr_state = ACQUIRE;
    endcase
    next_cdr_locked = next_cdr_state == LOCKED;
    next_cdr_tracking = next_cdr_state != ACQUIRE;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cdr_state <= ACQUIRE;
      quiet_cnt <= serdes_pkg::SILENT_BITS;
      lock_timer <= '0;
      ref_cnt <= 2'h0;
      warm <= 1'b0;
      prev_bit <= 1'b0;
      cdr_locked <= 1'b0;
      cdr_tracking <= 1'b0;
    end else begin
      cdr_state <= next_cdr_state;
      quiet_cnt <= next_quiet_cnt;
      lock_timer <= next_lock_timer;
      ref_cnt <= next_ref_cnt;
      warm <= next_warm;
      prev_bit <= next_prev_bit;
      cdr_locked <= next_cdr_locked;
      cdr_tracking <= next_cdr_tracking;
    end
  end

  // deserializer and comma alignment
  logic [9:0] rx_shift, next_rx_shift, win, next_rx_word;
  logic [3:0] rx_cnt, next_rx_cnt, rise;
  logic hit, next_align_sync, next_rx_word_clock;

  comma_detect #(
    .W(serdes_pkg::WORD_W),
    .PAT_A(serdes_pkg::COMMA_RD_NEG),
    .PAT_B(serdes_pkg::COMMA_RD_POS)
  ) u_comma (
    .win(win),
    .hit(hit)
  );

  always_comb begin
    win = {rx_shift[8:0], rx_bit};
    next_rx_shift = bit_en ? win : rx_shift;
    next_rx_word = rx_word;
    next_rx_cnt = rx_cnt;
    next_align_sync = align_sync;
    if (bit_en) begin
      if (align_en_s && hit) begin
        // boundary snaps to the comma, partial word is dropped
        next_rx_word = win;
        next_align_sync = 1'b1;
        next_rx_cnt = serdes_pkg::CNT_RESET;
      end else if (rx_cnt == serdes_pkg::LAST_BIT) begin
        next_rx_word = win;
        next_align_sync = 1'b0;
        next_rx_cnt = serdes_pkg::CNT_RESET;
      end else begin
        next_rx_cnt = 4'(rx_cnt + 4'h1);
      end
    end
    if (!align_en_s) next_align_sync = 1'b0;
    rise = edge_s ? serdes_pkg::RX_WORD_CLOCK_RISE_LATE
                  : serdes_pkg::RX_WORD_CLOCK_RISE_EARLY;
    next_rx_word_clock = (next_rx_cnt >= rise) &&
      (next_rx_cnt < 4'(rise + serdes_pkg::HALF_WORD));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_shift <= serdes_pkg::WORD_RESET;
      rx_word <= serdes_pkg::WORD_RESET;
      rx_cnt <= serdes_pkg::CNT_RESET;
      align_sync <= 1'b0;
      rx_word_clock <= 1'b0;
    end else begin
      rx_shift <= next_rx_shift;
      rx_word <= next_rx_word;
      rx_cnt <= next_rx_cnt;
      align_sync <= next_align_sync;
      rx_word_clock <= next_rx_word_clock;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_word_load;
    bit_en && tx_cnt == serdes_pkg::LAST_BIT;
  endsequence

  sequence s_comma_seen;
    bit_en && align_en_s && hit;
  endsequence

  a_tx_capture_word: assert property (
    strobe_s && !strobe_d |=> tx_hold == $past(tx_word_s))
    else $error("tx word not captured on strobe");
  a_tx_msb_first: assert property (
    s_word_load |=> tx_shift == $past(tx_hold) && line_out_pos ==
      (!$past(loop_s) && $past(tx_hold[9])))
    else $error("serializer did not start with bit 9");
  // a rate change inside a word stretches it, so low rate is left out
  a_word_clk_high: assert property (
    disable iff (!nrst || baud_low)
    $rose(word_clock_out) && !baud_low && $past(!baud_low)
      |-> word_clock_out [*5] ##1 !word_clock_out)
    else $error("word clock high time wrong");
  a_line_idle_loop: assert property (
    loop_s |=> !line_out_pos && line_out_neg)
    else $error("line pair not idle in loopback");
  a_loop_idle_line: assert property (
    !loop_s |=> !loop_out_pos && loop_out_neg)
    else $error("loop pair not idle on line");
  a_cdr_absent_acq: assert property (
    !present |=> cdr_state == ACQUIRE && !cdr_tracking ##1 !cdr_locked)
    else $error("recovery not acquiring without input");
  a_lock_in_time: assert property (
    cdr_state == RECOVER && warm |-> lock_timer <
      serdes_pkg::TIMER_W'(SYNC_WARM_CYC))
    else $error("warm lock overran");
  a_comma_align: assert property (
    s_comma_seen |=> align_sync && rx_word == $past(win) &&
      rx_cnt == serdes_pkg::CNT_RESET && !rx_word_clock)
    else $error("comma did not realign word");
  a_align_off_low: assert property (
    !align_en_s |=> !align_sync)
    else $error("sync high with alignment disabled");
  a_rx_last_bit: assert property (
    bit_en && rx_cnt == serdes_pkg::LAST_BIT && !(align_en_s && hit)
      |=> rx_word[0] == $past(rx_bit) && !align_sync)
    else $error("tenth bit not in bit 0");
endmodule

// ---- serdes_far_end.sv ----
`timescale 1ns/100ps
module serdes_far_end (
  // control from bench
  input wire logic [9:0] data_word,
  input wire logic line_cut,
  // transmit parallel side
  input wire logic word_clock_out,
  output logic [9:0] tx_word,
  output logic tx_word_strobe,
  output logic reference_clock,
  // serial media
  input wire logic line_out_pos,
  input wire logic line_out_neg,
  input wire logic loop_out_pos,
  input wire logic loop_out_neg,
  output logic line_in_pos,
  output logic line_in_neg,
  output logic loop_in_pos,
  output logic loop_in_neg
);
  logic pick_comma;
  // free running, phase unrelated to clk
  initial begin
    reference_clock = 1'b0;
    #7.3;
    forever #15 reference_clock = ~reference_clock;
  end
  initial begin
    tx_word = serdes_pkg::COMMA_RD_NEG;
    pick_comma = 1'b0;
  end
  // new word mid-way, settled long before the strobe rises
  always @(negedge word_clock_out) begin
    pick_comma <= ~pick_comma;
    tx_word <= pick_comma ? serdes_pkg::COMMA_RD_NEG : data_word;
  end
  assign tx_word_strobe = word_clock_out;
  // dark fibre when cut: static pair, no transitions
  assign line_in_pos = line_cut ? 1'b0 : line_out_pos;
  assign line_in_neg = line_cut ? 1'b1 : line_out_neg;
  assign loop_in_pos = line_cut ? 1'b0 : loop_out_pos;
  assign loop_in_neg = line_cut ? 1'b1 : loop_out_neg;
endmodule

// ---- gigabit_serdes_comma_align_tb.sv ----
`timescale 1ns/100ps
module gigabit_serdes_comma_align_tb;
  logic clk, nrst, loop_select, baud_select, align_enable, rx_edge_select;
  logic line_cut, reference_clock, tx_word_strobe, word_clock_out;
  logic [9:0] data_word, tx_word, rx_word;
  logic line_out_pos, line_out_neg, loop_out_pos, loop_out_neg;
  logic line_in_pos, line_in_neg, loop_in_pos, loop_in_neg;
  logic rx_word_clock, align_sync, cdr_locked, cdr_tracking;
  logic wc_d, wc_rise;
  logic [1:0] idle;
  logic [12:0] rows [4];
  int fail_count, comparisons, last_wait, i, k;

  gigabit_serdes_comma_align #(.SYNC_COLD_CYC(50), .SYNC_WARM_CYC(20)) DUT (
    .clk, .nrst, .reference_clock, .tx_word, .tx_word_strobe,
    .word_clock_out, .line_out_pos, .line_out_neg, .loop_out_pos,
    .loop_out_neg, .line_in_pos, .line_in_neg, .loop_in_pos, .loop_in_neg,
    .loop_select, .baud_select, .align_enable, .rx_edge_select, .rx_word,
    .rx_word_clock, .align_sync, .cdr_locked, .cdr_tracking);

  serdes_far_end far_end (
    .data_word, .line_cut, .word_clock_out, .tx_word, .tx_word_strobe,
    .reference_clock, .line_out_pos, .line_out_neg, .loop_out_pos,
    .loop_out_neg, .line_in_pos, .line_in_neg, .loop_in_pos, .loop_in_neg);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic step;
    @(posedge clk);
    #1;
    wc_rise = rx_word_clock & ~wc_d;
    wc_d = rx_word_clock;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return cdr_locked === 1'b1;
      1: return cdr_tracking === 1'b0;
      2: return wc_rise === 1'b1;
      default: return wc_rise === 1'b1 && align_sync === 1'b1;
    endcase
  endfunction

  // bounded wait; running out ends the run
  task automatic wait_for(input int s, input int n);
    last_wait = 0;
    do begin
      step();
      last_wait++;
    end while (!pick(s) && last_wait < n);
    if (!pick(s)) begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
    end
  endtask

  initial begin
    nrst = 1'b0;
    loop_select = 1'b0;
    baud_select = 1'b0;
    align_enable = 1'b1;
    rx_edge_select = 1'b0;
    line_cut = 1'b0;
    data_word = 10'h2AA;
    wc_d = 1'b0;
    wc_rise = 1'b0;
    fail_count = 0;
    comparisons = 0;
    // loop, baud, edge, word
    rows = '{13'h02AA, 13'h1555, 13'h0DC7, 13'h1A38};
    repeat (6) @(posedge clk);
    #1;
    check({1'b0, word_clock_out, line_out_pos, line_out_neg, loop_out_pos,
      loop_out_neg, align_sync, cdr_locked, cdr_tracking, rx_word_clock},
      10'h150);
    check(rx_word, serdes_pkg::WORD_RESET);
    nrst = 1'b1;
    $display("reset test done");
    wait_for(0, 400);
    check({9'h000, cdr_tracking}, 10'h001);
    $display("cold lock test done");
    for (i = 0; i < 4; i++) begin
      {loop_select, baud_select, rx_edge_select, data_word} = rows[i];
      repeat (100) step();
      wait_for(3, 1000);
      check(rx_word, serdes_pkg::COMMA_RD_NEG);
      idle = loop_select ? {line_out_pos, line_out_neg}
                         : {loop_out_pos, loop_out_neg};
      check({8'h00, idle}, 10'h001);
      wait_for(2, 400);
      check(10'(last_wait), baud_select ? 10'h014 : 10'h00A);
      check(rx_word, data_word);
      check({9'h000, align_sync}, 10'h000);
      $display("row %0d done", i);
    end
    align_enable = 1'b0;
    k = 0;
    repeat (4) step();
    repeat (200) begin
      step();
      if (align_sync !== 1'b0) k++;
    end
    check(10'(k), 10'h000);
    align_enable = 1'b1;
    wait_for(3, 1000);
    $display("align enable test done");
    line_cut = 1'b1;
    wait_for(1, 300);
    check({9'h000, cdr_locked}, 10'h000);
    line_cut = 1'b0;
    wait_for(0, 200);
    $display("relock test done");
    report_and_stop();
  end
endmodule
